/* gain_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// Dual-channel gain register bank reached over a four-wire serial port
module gain_register_bank #(
  parameter logic [7:0] REVISION_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] PRODUCT_CODE  = 8'hC1  // Arbitrary value
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe_n,
  output logic            first_channel_sleep,
  output logic            second_channel_sleep,
  output logic [7:0]      first_channel_bias_bus,
  output logic [7:0]      first_channel_atten_bus,
  output logic [7:0]      second_channel_bias_bus,
  output logic [7:0]      second_channel_atten_bus
);
  word_if     link ();
  logic       commit;
  logic [7:0] a_bias_reg;
  logic [7:0] a_atten_reg;
  logic [7:0] b_bias_reg;
  logic [7:0] b_atten_reg;
  logic       a_sleep_reg;
  logic       b_sleep_reg;
  logic       a_srst_reg;
  logic       b_srst_reg;
  logic [7:0] snap_reg;
  logic [6:0] rd_addr_reg;
  logic       wen;
  logic [7:0] wdat;
  logic [6:0] waddr;

  // Readback decode; unmapped locations return zero
  function automatic logic [7:0] read_reg(input logic [6:0] a);
    unique case (a)
      gain_bank_pkg::OFS_REVISION: read_reg = REVISION_CODE;
      gain_bank_pkg::OFS_PRODUCT:  read_reg = PRODUCT_CODE;
      gain_bank_pkg::OFS_SOFT_RST: read_reg = gain_bank_pkg::ZERO_BYTE;
      gain_bank_pkg::OFS_SLEEP:    read_reg = {3'h0, b_sleep_reg, 3'h0, a_sleep_reg};
      gain_bank_pkg::OFS_A_BIAS:   read_reg = a_bias_reg;
      gain_bank_pkg::OFS_A_ATTEN:  read_reg = a_atten_reg;
      gain_bank_pkg::OFS_B_BIAS:   read_reg = b_bias_reg;
      gain_bank_pkg::OFS_B_ATTEN:  read_reg = b_atten_reg;
      default:                     read_reg = gain_bank_pkg::ZERO_BYTE;
    endcase
  endfunction

  serial_link u_link (
    .sclk        (sclk),
    .rst         (rst),
    .cs_n        (cs_n),
    .sdi         (sdi),
    .rd_snapshot (snap_reg),
    .sdo         (sdo),
    .wr          (link)
  );

  toggle_sync u_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .toggle_in (link.toggle),
    .pulse     (commit)
  );

  // Word fields are stable for many fast cycles after the toggle lands
  assign wen   = commit & ~link.rd;
  assign wdat  = link.data;
  assign waddr = link.addr;

  // Snapshot of the one addressed readable byte; address follows the last committed word
  // so the serial side samples a steady byte rather than a moving mux
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_addr_reg <= 7'h00;
      snap_reg    <= 8'h00;
    end else begin
      if (commit) begin
        rd_addr_reg <= waddr;
      end
      snap_reg <= read_reg(rd_addr_reg);
    end
  end

  // Self-clearing soft reset requests; they live one cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      a_srst_reg <= 1'b0;
      b_srst_reg <= 1'b0;
    end else begin
      a_srst_reg <= wen && waddr == gain_bank_pkg::OFS_SOFT_RST
                    && wdat[gain_bank_pkg::BIT_CH_A];
      b_srst_reg <= wen && waddr == gain_bank_pkg::OFS_SOFT_RST
                    && wdat[gain_bank_pkg::BIT_CH_B];
    end
  end

  // Sleep bits; unaffected by soft reset so contents survive power-down
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      a_sleep_reg <= 1'b0;
      b_sleep_reg <= 1'b0;
    end else if (wen && waddr == gain_bank_pkg::OFS_SLEEP) begin
      a_sleep_reg <= wdat[gain_bank_pkg::BIT_CH_A];
      b_sleep_reg <= wdat[gain_bank_pkg::BIT_CH_B];
    end
  end

  // First channel control registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      a_bias_reg  <= gain_bank_pkg::BIAS_RESET;
      a_atten_reg <= gain_bank_pkg::ATTEN_RESET;
    end else if (a_srst_reg) begin
      a_bias_reg  <= gain_bank_pkg::BIAS_RESET;
      a_atten_reg <= gain_bank_pkg::ATTEN_RESET;
    end else if (wen && waddr == gain_bank_pkg::OFS_A_BIAS) begin
      a_bias_reg <= wdat;
    end else if (wen && waddr == gain_bank_pkg::OFS_A_ATTEN) begin
      a_atten_reg <= wdat;
    end
  end

  // Second channel control registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      b_bias_reg  <= gain_bank_pkg::BIAS_RESET;
      b_atten_reg <= gain_bank_pkg::ATTEN_RESET;
    end else if (b_srst_reg) begin
      b_bias_reg  <= gain_bank_pkg::BIAS_RESET;
      b_atten_reg <= gain_bank_pkg::ATTEN_RESET;
    end else if (wen && waddr == gain_bank_pkg::OFS_B_BIAS) begin
      b_bias_reg <= wdat;
    end else if (wen && waddr == gain_bank_pkg::OFS_B_ATTEN) begin
      b_atten_reg <= wdat;
    end
  end

  // Control outputs registered straight from the bank
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      first_channel_bias_bus   <= gain_bank_pkg::BIAS_RESET;
      first_channel_atten_bus  <= gain_bank_pkg::ATTEN_RESET;
      second_channel_bias_bus  <= gain_bank_pkg::BIAS_RESET;
      second_channel_atten_bus <= gain_bank_pkg::ATTEN_RESET;
      first_channel_sleep      <= 1'b0;
      second_channel_sleep     <= 1'b0;
    end else begin
      first_channel_bias_bus   <= a_bias_reg;
      first_channel_atten_bus  <= a_atten_reg;
      second_channel_bias_bus  <= b_bias_reg;
      second_channel_atten_bus <= b_atten_reg;
      first_channel_sleep      <= a_sleep_reg;
      second_channel_sleep     <= b_sleep_reg;
    end
  end

  // Output driver enable; the read line is output only, so it stays driven
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_oe_n <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* gain_bank_pkg.sv */
// Overview of operation
// - Seven-bit address; locations 8 to 127 reserved, read-only, return zero.
// - Locations 0 and 1 return fixed revision and product codes; writes ignored.
// - Soft reset register: bit 4 resets second channel, bit 0 first channel.
// - Soft reset request bits clear themselves and read back as zero.
// - Soft reset restores only that channel's registers to defaults.
// - Power-down register: bit 4 second channel, bit 0 first; one means sleep.
// - Bits 7-5 and 3-1 of reset and power-down registers read zero.
// - Location 4 drives first channel bias bus; reset by device or channel reset.
// - Location 5 drives first channel attenuator bus; same resets.
// - Location 6 drives second channel bias bus; same resets.
// - Location 7 drives second channel attenuator bus; same resets.
// - Bias registers default to hexadecimal 20.
// - Attenuator registers default to hexadecimal 14.
// - Sample serial input on rising clock while selected; commit each sixteenth bit.
// - Power-on reset loads defaults; power-down keeps register contents.
package gain_bank_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam logic [6:0] OFS_REVISION = 7'h00;
  localparam logic [6:0] OFS_PRODUCT  = 7'h01;
  localparam logic [6:0] OFS_SOFT_RST = 7'h02;
  localparam logic [6:0] OFS_SLEEP    = 7'h03;
  localparam logic [6:0] OFS_A_BIAS   = 7'h04;
  localparam logic [6:0] OFS_A_ATTEN  = 7'h05;
  localparam logic [6:0] OFS_B_BIAS   = 7'h06;
  localparam logic [6:0] OFS_B_ATTEN  = 7'h07;
  localparam int BIT_CH_A = 0;
  localparam int BIT_CH_B = 4;
  localparam logic [7:0] BIAS_RESET  = 8'h20;
  localparam logic [7:0] ATTEN_RESET = 8'h14;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;
  localparam int SYNC_STAGES = 2;
endpackage

/* word_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Word handed from the serial domain to the register domain
interface word_if;
  logic       toggle;
  logic [6:0] addr;
  logic [7:0] data;
  logic       rd;
  modport src (output toggle, output addr, output data, output rd);
  modport dst (input toggle, input addr, input data, input rd);
endinterface
`default_nettype wire

/* serial_link.sv */
`timescale 1ns/1ps
`default_nettype none
// Serial shifter on the master's clock; held idle while select is high
module serial_link (
  input  wire logic       sclk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  input  wire logic [7:0] rd_snapshot,
  output logic            sdo,
  word_if.src             wr
);
  logic [3:0]  cnt_reg;
  logic [14:0] shift_reg;
  logic [7:0]  out_reg;
  logic        tog_reg;
  logic [6:0]  addr_reg;
  logic [7:0]  data_reg;
  logic        rdw_reg;

  // Bit counter restarts whenever select rises; leftover bits dropped
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // Shift in MSB first
  always_ff @(posedge sclk) begin
    if (!cs_n) begin
      shift_reg <= {shift_reg[13:0], sdi};
    end
  end

  // Commit on sixteenth edge; toggle crosses to the register domain.
  // Only the device reset clears the toggle: clearing it on select would
  // make a second edge and commit the same word twice
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      tog_reg  <= 1'b0;
      addr_reg <= 7'h00;
      rdw_reg  <= 1'b0;
      data_reg <= 8'h00;
    end else if (!cs_n && cnt_reg == 4'hF) begin
      tog_reg  <= ~tog_reg;
      addr_reg <= shift_reg[13:7];
      rdw_reg  <= shift_reg[14];
      data_reg <= {shift_reg[6:0], sdi};
    end
  end

  // Read snapshot is taken after the eighth bit; the master must clock slowly
  // enough that the register domain has refreshed it, a limitation of the design
  // Whole byte loads at the eighth fall, so its MSB is set up for the ninth rise
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_reg <= 8'h00;
    end else if (cnt_reg == 4'h8) begin
      out_reg <= shift_reg[7] ? rd_snapshot : 8'h00;
    end else if (cnt_reg > 4'h8) begin
      out_reg <= {out_reg[6:0], 1'b0};
    end
  end

  assign sdo       = out_reg[7];
  assign wr.toggle = tog_reg;
  assign wr.addr   = addr_reg;
  assign wr.data   = data_reg;
  assign wr.rd     = rdw_reg;
endmodule
`default_nettype wire

/* toggle_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser followed by a toggle edge detector
module toggle_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic toggle_in,
  output logic      pulse
);
  logic [2:0] sync_reg;

  // First stage feeds only the second
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_reg <= 3'h0;
    end else begin
      sync_reg <= {sync_reg[1:0], toggle_in};
    end
  end

  assign pulse = sync_reg[2] ^ sync_reg[1];
endmodule
`default_nettype wire

/* gain_bank_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks of the gain bank
module gain_bank_properties (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic       sdo_oe_n,
  input  wire logic       first_channel_sleep,
  input  wire logic       second_channel_sleep,
  input  wire logic [7:0] first_channel_bias_bus,
  input  wire logic [7:0] first_channel_atten_bus,
  input  wire logic [7:0] second_channel_bias_bus,
  input  wire logic [7:0] second_channel_atten_bus
);
  logic [4:0] idle_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Cycles since select was low; 31 is well past the word sync latency
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idle_reg <= 5'h00;
    end else if (!cs_n) begin
      idle_reg <= 5'h00;
    end else if (idle_reg != 5'h1F) begin
      idle_reg <= idle_reg + 5'h01;
    end
  end
  sequence s_quiet;
    idle_reg == 5'h1F;
  endsequence
  sequence s_released;
    $fell(rst);
  endsequence
  AST_OE_DRIVEN: assert property (!$past(rst) |-> sdo_oe_n == 1'b0)
    else $error("read driver off");
  AST_A_BIAS_HOLD: assert property (s_quiet |-> $stable(first_channel_bias_bus))
    else $error("bias A moved");
  AST_A_ATTEN_HOLD: assert property (s_quiet |=> $stable(first_channel_atten_bus))
    else $error("atten A moved");
  AST_B_BIAS_HOLD: assert property (s_quiet |-> $stable(second_channel_bias_bus))
    else $error("bias B moved");
  AST_B_ATTEN_HOLD: assert property (s_quiet |=> $stable(second_channel_atten_bus))
    else $error("atten B moved");
  AST_SLEEP_HOLD: assert property (s_quiet |-> $stable({first_channel_sleep,
    second_channel_sleep}))
    else $error("sleep moved");
  AST_RST_BIAS: assert property (s_released |-> first_channel_bias_bus == 8'h20 &&
    second_channel_bias_bus == 8'h20)
    else $error("bias default");
  AST_RST_ATTEN: assert property (s_released |-> first_channel_atten_bus == 8'h14 &&
    second_channel_atten_bus == 8'h14)
    else $error("atten default");
  AST_RST_SLEEP: assert property (s_released |-> !first_channel_sleep &&
    !second_channel_sleep)
    else $error("sleep default");
endmodule
bind gain_register_bank gain_bank_properties chk_u (.ref_clk, .rst, .cs_n, .sdo_oe_n,
  .first_channel_sleep, .second_channel_sleep, .first_channel_bias_bus,
  .first_channel_atten_bus, .second_channel_bias_bus, .second_channel_atten_bus);
`default_nettype wire

/* serial_master.sv */
`timescale 1ns/1ps
`default_nettype none
// Serial master; its clock stands low between frames
module serial_master (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // Sends nbits from bit 31 down, 30 ns period; data-byte sdo bits land in rd
  task automatic frame(input logic [31:0] w, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    for (int k = 0; k < nbits; k++) begin
      sdi = w[31-k];
      #15;
      // Sample just before the rise, while the bit set up at the fall stands
      if (k % 16 >= 8) rd = {rd[6:0], sdo};
      sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    #15 cs_n = 1'b1;
    sdi = ~sdi; // Released line must not show a stale bit
    #30; // Deselect gap so a following frame never glitches select
  endtask
endmodule
`default_nettype wire

/* tb_dual_channel_gain_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// Bench with an integer register map as reference
module tb_dual_channel_gain_register_bank;
  localparam logic [7:0] REV = 8'h6E; // Arbitrary value
  localparam logic [7:0] PRD = 8'h3D; // Arbitrary value
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, sdi, sdo, sdo_oe_n, first_channel_sleep, second_channel_sleep;
  logic [7:0] first_channel_bias_bus, first_channel_atten_bus, got;
  logic [7:0] second_channel_bias_bus, second_channel_atten_bus;
  logic [31:0] lfsr = 32'h3A7267D0;
  int exp_reg [0:7];
  int bad_count = 0;
  int n_compared = 0;
  always #2 ref_clk = ~ref_clk;
  gain_register_bank #(.REVISION_CODE(REV), .PRODUCT_CODE(PRD)) dut_u (.ref_clk, .rst,
    .sclk, .cs_n, .sdi, .sdo, .sdo_oe_n, .first_channel_sleep, .second_channel_sleep,
    .first_channel_bias_bus, .first_channel_atten_bus, .second_channel_bias_bus,
    .second_channel_atten_bus);
  serial_master mst_u (.sclk, .cs_n, .sdi, .sdo);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reference effect of one committed write; read-only places keep their value
  task automatic mwr(input int a, input int d);
    if (a == 3) exp_reg[3] = d & 8'h11;
    if (a > 3 && a < 8) exp_reg[a] = d;
    if (a == 2 && d[0]) begin
      exp_reg[4] = 8'h20;
      exp_reg[5] = 8'h14;
    end
    if (a == 2 && d[4]) begin
      exp_reg[6] = 8'h20;
      exp_reg[7] = 8'h14;
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    mst_u.frame({1'b0, a, d, 16'h0000}, 16, got);
    mwr(a, d);
    repeat (12) @(posedge ref_clk);
  endtask
  // Read answers with the previous word's address, so the word goes twice
  task automatic rd_chk(input logic [6:0] a);
    mst_u.frame({1'b1, a, 8'h00, 1'b1, a, 8'h00}, 32, got);
    chk(got, (a < 8) ? exp_reg[a] : 0);
  endtask
  task automatic bus_chk;
    chk(first_channel_bias_bus, exp_reg[4]);
    chk(first_channel_atten_bus, exp_reg[5]);
    chk(second_channel_bias_bus, exp_reg[6]);
    chk(second_channel_atten_bus, exp_reg[7]);
    chk({3'h0, second_channel_sleep, 3'h0, first_channel_sleep}, exp_reg[3]);
  endtask
  initial begin
    exp_reg = '{REV, PRD, 0, 0, 8'h20, 8'h14, 8'h20, 8'h14};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({7'h00, sdo_oe_n}, 8'h00);
    bus_chk();
    for (int a = 0; a < 9; a++) rd_chk(a);
    rd_chk(7'h7F);
    // Random settings; first channel as two words in one frame
    lfsr = nxt(lfsr);
    mst_u.frame({8'h04, lfsr[7:0], 8'h05, lfsr[15:8]}, 32, got);
    mwr(4, lfsr[7:0]);
    mwr(5, lfsr[15:8]);
    wr(6, lfsr[23:16]);
    wr(7, lfsr[31:24]);
    bus_chk();
    for (int a = 0; a < 4; a++) wr(a ? 7'h7F : 7'h08, 8'hFF);
    wr(0, 8'hFF);
    wr(1, 8'hFF);
    wr(3, 8'hFF);
    bus_chk();
    for (int a = 0; a < 8; a++) rd_chk(a);
    wr(2, 8'h01);
    bus_chk();
    rd_chk(2);
    wr(3, 8'h10);
    wr(2, 8'hEE);
    bus_chk();
    // Second channel soft reset; first channel and sleep bits stay
    wr(2, 8'h10);
    bus_chk();
    rd_chk(2);
    // Bits past a whole word are dropped; a short word commits nothing
    mst_u.frame({8'h04, 8'h5A, 16'hFFFF}, 21, got);
    mwr(4, 8'h5A);
    mst_u.frame({8'h05, 8'h3C, 16'h0000}, 12, got);
    repeat (12) @(posedge ref_clk);
    bus_chk();
    end_of_test();
  end
  // Run needs about 30 us; a hang ends here
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
